// ===== hw/cbs_pkg.sv
// context bank table package: sizes, field layouts, encodings, shared types.
// assumes one clock domain; every structured port of the block uses these types.

package cbs_pkg;

  // ----------------------------------------------------------------
  // sizes and counts
  // ----------------------------------------------------------------
  localparam int                 NUM_BANKS     = 8;
  localparam int                 BANK_W        = 3;
  localparam int                 IDX_W         = 4;
  localparam logic [IDX_W-1:0]   BANK_COUNT    = 4'h8;
  localparam logic [IDX_W-1:0]   S2_ONLY_COUNT = 4'h2;

  // ----------------------------------------------------------------
  // config access selects and identification layout
  // ----------------------------------------------------------------
  localparam logic [1:0]         SEL_ATTR1     = 2'h0;
  localparam logic [1:0]         SEL_ATTR2     = 2'h1;
  localparam logic [1:0]         SEL_ID1       = 2'h2;
  localparam int                 ID1_COUNT_LSB = 0;
  localparam int                 ID1_S2_LSB    = 16;
  localparam logic               UNIMPL_FAULT  = 1'b1;
  localparam logic               WIDE_TAG_SUPP = 1'b1;

  // ----------------------------------------------------------------
  // bank type encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]         TYPE_S2        = 2'h0;
  localparam logic [1:0]         TYPE_S1_BYPASS = 2'h1;
  localparam logic [1:0]         TYPE_S1_FAULT  = 2'h2;
  localparam logic [1:0]         TYPE_S1_NESTED = 2'h3;
  localparam logic [31:0]        ATTR_RST       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // register layouts, lsb last
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [12:0] rsvd;
    logic        hyp_sel;
    logic [1:0]  bank_type;
    logic [7:0]  nest_bank;
    logic [7:0]  vm_tag;
  } cbs_attr1_t;

  typedef struct packed {
    logic [15:0] wide_tag;
    logic [13:0] rsvd;
    logic        mon_sel;
    logic        wide_addr;
  } cbs_attr2_t;

  // ----------------------------------------------------------------
  // port carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic             secure;
    logic             write;
    logic [1:0]       sel;
    logic [IDX_W-1:0] bank;
    logic [31:0]      wdata;
  } cbs_cfg_req_t;

  typedef struct packed {
    logic        done;
    logic        fault;
    logic [31:0] rdata;
  } cbs_cfg_rsp_t;

  typedef struct packed {
    logic             valid;
    logic             maint;
    logic [IDX_W-1:0] bank;
  } cbs_lk_req_t;

  typedef struct packed {
    logic             done;
    logic             maint;
    logic [IDX_W-1:0] bank;
    logic             secure;
    logic             use_low;
    logic             use_high;
    logic             unpred;
    logic             invalid_ctx;
    logic             bypass;
    logic             nested;
    logic [7:0]       nest_bank;
    logic             tag_match;
    logic [15:0]      tag;
  } cbs_lk_rsp_t;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  function automatic logic bank_is_secure(input logic [IDX_W-1:0] bank,
                                          input logic [IDX_W-1:0] ns_count);
    return bank >= ns_count;
  endfunction

  function automatic logic [15:0] eff_tag(input cbs_attr1_t a1, input cbs_attr2_t a2,
                                          input logic wide_en);
    return (wide_en && WIDE_TAG_SUPP) ? a2.wide_tag : {8'h00, a1.vm_tag};
  endfunction

endpackage

// ===== hw/cbs_ttb_sel.sv
// table base selection for one bank, purely combinational.
// assumes attribute fields come straight from the bank table registers.
`timescale 1ns/1ps

module cbs_ttb_sel (
  // bank attributes
  input  wire logic       secure,
  input  wire logic [1:0] bank_type,
  input  wire logic       wide_addr,
  input  wire logic       hyp_sel,
  input  wire logic       mon_sel,
  // selection
  output logic            use_low,
  output logic            use_high,
  output logic            unpred,
  output logic            invalid_ctx
);

  always_comb begin
    use_low     = 1'b1;
    use_high    = 1'b0;
    unpred      = 1'b0;
    invalid_ctx = secure && (bank_type != cbs_pkg::TYPE_S1_BYPASS);
    if (!secure) begin
      // extended address enable has no input at all
      if (bank_type == cbs_pkg::TYPE_S2) begin
        use_high = 1'b0;
      end else if (hyp_sel) begin
        use_high = 1'b0;
      end else begin
        use_high = 1'b1;
      end
    end else if (!wide_addr) begin
      use_high = !hyp_sel;
    end else if (hyp_sel && mon_sel) begin
      // no defined base: select none, flag it
      use_low = 1'b0;
      unpred  = 1'b1;
    end else if (hyp_sel ^ mon_sel) begin
      use_high = 1'b0;
    end else begin
      use_high = 1'b1;
    end
  end

endmodule

// ===== hw/cbs_ctx_irq.sv
// per-bank sticky context interrupt lines.
// assumes set and clear pulses are on clk_sys.
`timescale 1ns/1ps

module cbs_ctx_irq (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // events
  input  wire logic [cbs_pkg::NUM_BANKS-1:0] set,
  input  wire logic [cbs_pkg::NUM_BANKS-1:0] clear,
  // lines
  output logic      [cbs_pkg::NUM_BANKS-1:0] irq
);

  typedef struct packed {
    logic [cbs_pkg::NUM_BANKS-1:0] irq;
  } cbs_irq_state_t;

  cbs_irq_state_t st;
  cbs_irq_state_t next_st;

  always_comb begin
    // set beats clear so a fault in the clear cycle is kept
    next_st.irq = (st.irq & ~clear) | set;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irq = st.irq;

endmodule

// ===== hw/cbs_bank_table.sv
// context bank attribute table with security split and table base choice.
// assumes config and lookup requests are driven from logic on clk_sys.
`timescale 1ns/1ps

module cbs_bank_table (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // allocation and tag configuration
  input  wire logic [cbs_pkg::IDX_W-1:0]     nonsecure_bank_count_override,
  input  wire logic                          wide_machine_tag_enable,
  output logic      [cbs_pkg::IDX_W-1:0]     implemented_bank_count_ns,
  // configuration access
  input  wire cbs_pkg::cbs_cfg_req_t         cfg_req,
  output cbs_pkg::cbs_cfg_rsp_t              cfg_rsp,
  // lookup and maintenance
  input  wire cbs_pkg::cbs_lk_req_t          lk_req,
  output cbs_pkg::cbs_lk_rsp_t               lk_rsp,
  // context interrupts
  input  wire logic [cbs_pkg::NUM_BANKS-1:0] ctx_fault,
  input  wire logic [cbs_pkg::NUM_BANKS-1:0] ctx_irq_clear,
  output logic      [cbs_pkg::NUM_BANKS-1:0] ctx_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cbs_pkg::cbs_attr1_t [cbs_pkg::NUM_BANKS-1:0] attr1;
    cbs_pkg::cbs_attr2_t [cbs_pkg::NUM_BANKS-1:0] attr2;
    logic [cbs_pkg::NUM_BANKS-1:0]                sec_map;
    logic [cbs_pkg::IDX_W-1:0]                    ns_count;
    cbs_pkg::cbs_cfg_rsp_t                        cfg_rsp;
    cbs_pkg::cbs_lk_rsp_t                         lk_rsp;
  } cbs_state_t;

  cbs_state_t                    st;
  cbs_state_t                    next_st;

  // ----------------------------------------------------------------
  // lookup bank decode
  // ----------------------------------------------------------------
  logic [cbs_pkg::BANK_W-1:0]    lk_idx;
  cbs_pkg::cbs_attr1_t           lk_a1;
  cbs_pkg::cbs_attr2_t           lk_a2;
  logic                          lk_sec;
  logic                          sel_low;
  logic                          sel_high;
  logic                          sel_unpred;
  logic                          sel_invalid;
  logic [cbs_pkg::NUM_BANKS-1:0] irq_set;
  logic [cbs_pkg::NUM_BANKS-1:0] irq_lines;

  assign lk_idx = lk_req.bank[cbs_pkg::BANK_W-1:0];
  assign lk_a1  = st.attr1[lk_idx];
  assign lk_a2  = st.attr2[lk_idx];
  assign lk_sec = st.sec_map[lk_idx];

  cbs_ttb_sel u_ttb_sel (
    .secure      (lk_sec),
    .bank_type   (lk_a1.bank_type),
    .wide_addr   (lk_a2.wide_addr),
    .hyp_sel     (lk_a1.hyp_sel),
    .mon_sel     (lk_a2.mon_sel),
    .use_low     (sel_low),
    .use_high    (sel_high),
    .unpred      (sel_unpred),
    .invalid_ctx (sel_invalid)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [cbs_pkg::IDX_W-1:0]  ns_cnt;
    logic [cbs_pkg::BANK_W-1:0] ci;
    logic                       impl;
    logic                       vis;
    logic                       map_now;
    cbs_pkg::cbs_attr1_t        a1;
    cbs_pkg::cbs_attr2_t        a2;
    ns_cnt  = nonsecure_bank_count_override;
    ci      = cfg_req.bank[cbs_pkg::BANK_W-1:0];
    impl    = cfg_req.bank < cbs_pkg::BANK_COUNT;
    vis     = cfg_req.secure || !st.sec_map[ci];
    map_now = 1'b0;
    a1      = st.attr1[ci];
    a2      = st.attr2[ci];
    next_st = st;
    next_st.cfg_rsp = '0;
    next_st.lk_rsp  = '0;

    // ------------------------------------------------------------
    // security split
    // ------------------------------------------------------------
    // stage-2-only banks are handed to the secure side only in the cycle after the first edge out of reset, from the zero reset count
    if (ns_cnt < cbs_pkg::S2_ONLY_COUNT) begin
      ns_cnt = cbs_pkg::S2_ONLY_COUNT;
    end else if (ns_cnt > cbs_pkg::BANK_COUNT) begin
      ns_cnt = cbs_pkg::BANK_COUNT;
    end
    next_st.ns_count = ns_cnt;
    for (int i = 0; i < cbs_pkg::NUM_BANKS; i++) begin
      // secure banks are those at or above the non-secure count
      map_now = cbs_pkg::bank_is_secure(cbs_pkg::IDX_W'(i), st.ns_count);
      next_st.sec_map[i] = map_now;
      if (map_now != st.sec_map[i]) begin
        // stale value would leak across worlds; clear and let software set it
        next_st.attr2[i].wide_addr = 1'b0;
      end
    end

    // ------------------------------------------------------------
    // configuration access
    // ------------------------------------------------------------
    if (cfg_req.valid) begin
      next_st.cfg_rsp.done = 1'b1;
      case (cfg_req.sel)
        cbs_pkg::SEL_ID1: begin
          if (!cfg_req.write) begin
            next_st.cfg_rsp.rdata =
              (32'(cfg_req.secure ? cbs_pkg::BANK_COUNT : st.ns_count)
               << cbs_pkg::ID1_COUNT_LSB)
              | (32'(cbs_pkg::S2_ONLY_COUNT) << cbs_pkg::ID1_S2_LSB);
          end
        end
        cbs_pkg::SEL_ATTR1: begin
          if (!impl) begin
            next_st.cfg_rsp.fault = cbs_pkg::UNIMPL_FAULT;
          end else if (vis && cfg_req.write) begin
            a1      = cbs_pkg::cbs_attr1_t'(cfg_req.wdata);
            a1.rsvd = '0;
            if (wide_machine_tag_enable && cbs_pkg::WIDE_TAG_SUPP) begin
              a1.vm_tag = '0;
            end
            if (cfg_req.bank < cbs_pkg::S2_ONLY_COUNT) begin
              a1.bank_type = cbs_pkg::TYPE_S2;
            end
            next_st.attr1[ci] = a1;
          end else if (vis) begin
            if (wide_machine_tag_enable && cbs_pkg::WIDE_TAG_SUPP) begin
              a1.vm_tag = '0;
            end
            next_st.cfg_rsp.rdata = a1;
          end
        end
        cbs_pkg::SEL_ATTR2: begin
          if (!impl) begin
            next_st.cfg_rsp.fault = cbs_pkg::UNIMPL_FAULT;
          end else if (vis && cfg_req.write) begin
            a2      = cbs_pkg::cbs_attr2_t'(cfg_req.wdata);
            a2.rsvd = '0;
            if (!(wide_machine_tag_enable && cbs_pkg::WIDE_TAG_SUPP)) begin
              a2.wide_tag = '0;
            end
            next_st.attr2[ci] = a2;
          end else if (vis) begin
            if (!(wide_machine_tag_enable && cbs_pkg::WIDE_TAG_SUPP)) begin
              a2.wide_tag = '0;
            end
            next_st.cfg_rsp.rdata = a2;
          end
        end
        default: begin
          next_st.cfg_rsp.rdata = '0;
        end
      endcase
    end

    // ------------------------------------------------------------
    // lookup: sees attributes before a same-cycle config write
    // ------------------------------------------------------------
    if (lk_req.valid) begin
      next_st.lk_rsp.done  = 1'b1;
      next_st.lk_rsp.maint = lk_req.maint;
      next_st.lk_rsp.bank  = lk_req.bank;
      if (lk_req.bank >= cbs_pkg::BANK_COUNT) begin
        next_st.lk_rsp.invalid_ctx = 1'b1;
      end else begin
        next_st.lk_rsp.secure      = lk_sec;
        next_st.lk_rsp.use_low     = sel_low;
        next_st.lk_rsp.use_high    = sel_high;
        next_st.lk_rsp.unpred      = sel_unpred;
        next_st.lk_rsp.invalid_ctx = sel_invalid;
        next_st.lk_rsp.bypass      = lk_a1.bank_type == cbs_pkg::TYPE_S1_BYPASS;
        next_st.lk_rsp.nested      = lk_a1.bank_type == cbs_pkg::TYPE_S1_NESTED;
        next_st.lk_rsp.nest_bank   = lk_a1.nest_bank;
        // tag is carried on secure lookups but never used to match
        next_st.lk_rsp.tag         = cbs_pkg::eff_tag(lk_a1, lk_a2, wide_machine_tag_enable);
        next_st.lk_rsp.tag_match   = !lk_sec && !lk_a1.hyp_sel
                                     && (lk_a1.bank_type != cbs_pkg::TYPE_S2);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // attributes have no architected reset value; zero keeps sim clean
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // context interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = ctx_fault;
    if (st.lk_rsp.done && st.lk_rsp.invalid_ctx && (st.lk_rsp.bank < cbs_pkg::BANK_COUNT)) begin
      irq_set = ctx_fault
                | (cbs_pkg::NUM_BANKS'(1) << st.lk_rsp.bank[cbs_pkg::BANK_W-1:0]);
    end
  end

  cbs_ctx_irq u_ctx_irq (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .set     (irq_set),
    .clear   (ctx_irq_clear),
    .irq     (irq_lines)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign implemented_bank_count_ns = st.ns_count;
  assign cfg_rsp                   = st.cfg_rsp;
  assign lk_rsp                    = st.lk_rsp;
  assign ctx_irq                   = irq_lines;

endmodule

// ===== tb/cbs_bank_table_properties.sv
// port checker for cbs_bank_table, bound at the foot of this file.
// assumes one clock domain and the reset contract of the block.
`timescale 1ns/1ps

module cbs_bank_table_properties (
  // clock and reset
  input wire logic                          clk_sys,
  input wire logic                          nrst,
  // allocation and access
  input wire logic [cbs_pkg::IDX_W-1:0]     nonsecure_bank_count_override,
  input wire logic                          wide_machine_tag_enable,
  input wire logic [cbs_pkg::IDX_W-1:0]     implemented_bank_count_ns,
  input wire cbs_pkg::cbs_cfg_req_t         cfg_req,
  input wire cbs_pkg::cbs_cfg_rsp_t         cfg_rsp,
  input wire cbs_pkg::cbs_lk_req_t          lk_req,
  input wire cbs_pkg::cbs_lk_rsp_t          lk_rsp,
  // interrupts
  input wire logic [cbs_pkg::NUM_BANKS-1:0] ctx_fault,
  input wire logic [cbs_pkg::NUM_BANKS-1:0] ctx_irq_clear,
  input wire logic [cbs_pkg::NUM_BANKS-1:0] ctx_irq
);
  // ------------------------------
  // helpers
  // ------------------------------
  logic [3:0] exp_cnt;
  logic [3:0] cnt_d1;
  logic [3:0] cnt_d2;
  logic       steady;
  logic [7:0] keep;
  logic [7:0] drop;
  logic [7:0] inv_set;

  assign exp_cnt = (nonsecure_bank_count_override < 4'h2) ? 4'h2 :
                   (nonsecure_bank_count_override > 4'h8) ? 4'h8 : nonsecure_bank_count_override;
  // the secure map lags the count, so only judge it once the count held
  assign steady  = implemented_bank_count_ns == cnt_d1 && cnt_d1 == cnt_d2;
  assign inv_set = (lk_rsp.done && lk_rsp.invalid_ctx && lk_rsp.bank < cbs_pkg::BANK_COUNT) ?
                   (8'h01 << lk_rsp.bank[2:0]) : 8'h00;
  assign keep    = ctx_irq & ~ctx_irq_clear;
  assign drop    = ctx_irq_clear & ~ctx_fault & ~inv_set;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_d1 <= 4'h0;
      cnt_d2 <= 4'h0;
    end else begin
      cnt_d1 <= implemented_bank_count_ns;
      cnt_d2 <= cnt_d1;
    end
  end

  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_cfg_empty;
    cfg_rsp.done && !cfg_rsp.fault && cfg_rsp.rdata == 32'h0;
  endsequence
  sequence s_cfg_fault;
    cfg_rsp.done && cfg_rsp.fault && cfg_rsp.rdata == 32'h0;
  endsequence

  a_count_clamp: assert property (
    $past(nrst) |-> implemented_bank_count_ns == $past(exp_cnt))
    else $error("ns count is not the clamped override");
  a_secure_top: assert property (
    lk_rsp.done && lk_rsp.bank < cbs_pkg::BANK_COUNT && steady
    |-> lk_rsp.secure == (lk_rsp.bank >= implemented_bank_count_ns))
    else $error("bank security not split from the top");
  a_ns_hidden: assert property (
    cfg_req.valid && !cfg_req.secure && !cfg_req.write && cfg_req.sel != cbs_pkg::SEL_ID1
    && cfg_req.bank >= implemented_bank_count_ns && cfg_req.bank < cbs_pkg::BANK_COUNT
    && steady |=> s_cfg_empty)
    else $error("ns read of secure bank not empty");
  a_unimpl_fault: assert property (
    cfg_req.valid && cfg_req.sel <= cbs_pkg::SEL_ATTR2 && cfg_req.bank >= cbs_pkg::BANK_COUNT
    |=> s_cfg_fault)
    else $error("unimplemented attribute access did not fault");
  a_id_count: assert property (
    cfg_req.valid && !cfg_req.write && !cfg_req.secure && cfg_req.sel == cbs_pkg::SEL_ID1
    |=> cfg_rsp.rdata[3:0] == $past(implemented_bank_count_ns)
    && cfg_rsp.rdata[19:16] == cbs_pkg::S2_ONLY_COUNT)
    else $error("ns identification count wrong");
  a_lk_unimpl: assert property (
    lk_req.valid && lk_req.bank >= cbs_pkg::BANK_COUNT
    |=> lk_rsp.done && lk_rsp.invalid_ctx && lk_rsp.bank == $past(lk_req.bank))
    else $error("lookup of missing bank not invalid");
  a_nest_or_bypass: assert property (
    lk_rsp.done |-> !(lk_rsp.bypass && lk_rsp.nested))
    else $error("bank both nested and bypass");
  a_secure_untagged: assert property (
    lk_rsp.done && lk_rsp.secure |-> !lk_rsp.tag_match)
    else $error("secure lookup matched on tag");
  a_irq_set: assert property (
    |ctx_fault |=> (ctx_irq & $past(ctx_fault)) == $past(ctx_fault))
    else $error("context fault did not raise its line");
  a_irq_hold: assert property (
    |keep |=> (ctx_irq & $past(keep)) == $past(keep))
    else $error("context line dropped without clear");
  a_irq_clear: assert property (
    |drop |=> (ctx_irq & $past(drop)) == 8'h00)
    else $error("context line not cleared");
endmodule

bind cbs_bank_table cbs_bank_table_properties i_props (
  .clk_sys, .nrst, .nonsecure_bank_count_override, .wide_machine_tag_enable,
  .implemented_bank_count_ns, .cfg_req, .cfg_rsp, .lk_req, .lk_rsp,
  .ctx_fault, .ctx_irq_clear, .ctx_irq
);

// ===== tb/cbs_bank_table_test.sv
// self-checking bench for cbs_bank_table.
// assumes the port checker is bound in by its own file.
`timescale 1ns/1ps

module cbs_bank_table_test;
  // ------------------------------
  // signals
  // ------------------------------
  logic                  clk_sys      = 1'b0;
  logic                  nrst         = 1'b0;
  logic [3:0]            ovr          = 4'h6;
  logic                  wide_en      = 1'b0;
  logic [3:0]            ns_cnt;
  cbs_pkg::cbs_cfg_req_t cfg_req      = '0;
  cbs_pkg::cbs_cfg_rsp_t cfg_rsp;
  cbs_pkg::cbs_lk_req_t  lk_req       = '0;
  cbs_pkg::cbs_lk_rsp_t  lk_rsp;
  logic [7:0]            fault        = 8'h00;
  logic [7:0]            clr          = 8'h00;
  logic [7:0]            irq;
  int                    mismatches   = 0;
  int                    total_checks = 0;
  int                    cycles       = 0;
  cbs_pkg::cbs_cfg_rsp_t c;
  cbs_pkg::cbs_lk_rsp_t  l;
  logic [7:0]            row;
  logic [3:0]            bk;
  // sec,type,hyp,wide,mon,low,high per row
  // no secure row sets wide, hyp and monitor together
  // each row's bank is written before it is looked up
  logic [7:0]            rows [12] = '{8'h23, 8'h2B, 8'h32, 8'h3A, 8'h02, 8'h1A,
                                       8'h43, 8'hA3, 8'hB2, 8'hAB, 8'hAE, 8'hBA};

  always #5 clk_sys = ~clk_sys;

  cbs_bank_table i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .nonsecure_bank_count_override(ovr),
    .wide_machine_tag_enable(wide_en), .implemented_bank_count_ns(ns_cnt),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .lk_req(lk_req), .lk_rsp(lk_rsp),
    .ctx_fault(fault), .ctx_irq_clear(clr), .ctx_irq(irq)
  );

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access: request held for its taking edge, answer read a cycle on
  task automatic cfg(input logic sec, input logic wr, input logic [1:0] sel,
                     input logic [3:0] bank, input logic [31:0] data);
    @(posedge clk_sys);
    #1;
    cfg_req = '{1'b1, sec, wr, sel, bank, data};
    @(posedge clk_sys);
    #1;
    cfg_req.valid = 1'b0;
    c = cfg_rsp;
  endtask

  task automatic look(input logic [3:0] bank, input logic mnt);
    @(posedge clk_sys);
    #1;
    lk_req = '{1'b1, mnt, bank};
    @(posedge clk_sys);
    #1;
    lk_req.valid = 1'b0;
    l = lk_rsp;
  endtask

  // a hang costs a mismatch rather than the run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("ns count", 32'h6, ns_cnt);
    cfg(1'b0, 1'b0, cbs_pkg::SEL_ID1, 4'h0, 32'h0);
    chk("ns id count", 32'h6, c.rdata[3:0]);
    chk("s2 only count", 32'h2, c.rdata[19:16]);
    cfg(1'b1, 1'b0, cbs_pkg::SEL_ID1, 4'h0, 32'h0);
    chk("s id count", 32'h8, c.rdata[3:0]);
    cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR1, 4'h7, 32'h0001_0042);
    cfg(1'b0, 1'b1, cbs_pkg::SEL_ATTR1, 4'h7, 32'h0000_0000);
    cfg(1'b0, 1'b0, cbs_pkg::SEL_ATTR1, 4'h7, 32'h0);
    chk("ns read secure", 32'h0, c.rdata);
    cfg(1'b1, 1'b0, cbs_pkg::SEL_ATTR1, 4'h7, 32'h0);
    chk("s read back", 32'h0001_0042, c.rdata);
    cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR2, 4'h8, 32'hFFFF_FFFF);
    chk("unimpl fault", 32'h1, c.fault);
    cfg(1'b1, 1'b0, cbs_pkg::SEL_ATTR1, 4'hF, 32'h0);
    chk("unimpl rdata", 32'h0, c.rdata);
    cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR1, 4'h0, 32'h0001_0000);
    cfg(1'b1, 1'b0, cbs_pkg::SEL_ATTR1, 4'h0, 32'h0);
    chk("bank0 type", 32'h0, c.rdata[17:16]);
    for (int i = 0; i < 12; i++) begin
      row = rows[i];
      bk  = row[7] ? 4'h7 : 4'h3;
      cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR1, bk, {13'h0, row[4], row[6:5], 16'h0011});
      cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR2, bk, {30'h0, row[2], row[3]});
      look(bk, row[0]);
      chk("use low", row[1], l.use_low);
      chk("use high", row[0], l.use_high);
      chk("unpred", 32'h0, l.unpred);
      chk("tag match", !row[7] && !row[4] && row[6:5] != 2'h0, l.tag_match);
      chk("maint", row[0], l.maint);
      chk("secure", row[7], l.secure);
    end
    // outer and nested banks both carry tag zero
    cfg(1'b0, 1'b1, cbs_pkg::SEL_ATTR1, 4'h2, 32'h0003_0500);
    look(4'h2, 1'b0);
    chk("nested", 32'h1, l.nested);
    chk("nest bank", 32'h5, l.nest_bank);
    cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR1, 4'h6, 32'h0003_0000);
    look(4'h6, 1'b0);
    chk("secure nested", 32'h1, l.invalid_ctx);
    fault = 8'h04;
    @(posedge clk_sys);
    #1;
    chk("irq set", 32'h44, irq);
    clr = 8'h44;
    @(posedge clk_sys);
    #1;
    chk("irq set wins", 32'h04, irq);
    fault = 8'h00;
    clr   = 8'h04;
    @(posedge clk_sys);
    #1;
    chk("irq cleared", 32'h00, irq);
    clr = 8'h00;
    cfg(1'b0, 1'b1, cbs_pkg::SEL_ATTR1, 4'h4, 32'h0001_00A5);
    cfg(1'b0, 1'b1, cbs_pkg::SEL_ATTR2, 4'h4, 32'h1234_0000);
    cfg(1'b0, 1'b0, cbs_pkg::SEL_ATTR2, 4'h4, 32'h0);
    chk("tag16 off", 32'h0, c.rdata[31:16]);
    look(4'h4, 1'b1);
    chk("tag8", 32'h00A5, l.tag);
    chk("bypass", 32'h1, l.bypass);
    wide_en = 1'b1;
    cfg(1'b0, 1'b1, cbs_pkg::SEL_ATTR2, 4'h4, 32'hBEEF_0000);
    cfg(1'b0, 1'b0, cbs_pkg::SEL_ATTR1, 4'h4, 32'h0);
    chk("tag8 off", 32'h0, c.rdata[7:0]);
    look(4'h4, 1'b1);
    chk("tag16", 32'hBEEF, l.tag);
    wide_en = 1'b0;
    cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR2, 4'h5, 32'h0000_0001);
    // moving bank 5 to the secure side must not carry its wide bit over
    ovr = 4'h5;
    repeat (3) @(posedge clk_sys);
    cfg(1'b1, 1'b0, cbs_pkg::SEL_ATTR2, 4'h5, 32'h0);
    chk("wide after move", 32'h0, c.rdata[0]);
    chk("ns count moved", 32'h5, ns_cnt);
    // secure software writes the wide bit as zero again after the move
    cfg(1'b1, 1'b1, cbs_pkg::SEL_ATTR2, 4'h5, 32'h0000_0000);
    look(4'h5, 1'b0);
    chk("moved secure", 32'h1, l.secure);
    look(4'h9, 1'b0);
    chk("unimpl look", 32'h1, l.invalid_ctx);
    ovr = 4'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("clamp low", 32'h2, ns_cnt);
    look(4'h1, 1'b0);
    chk("s2 bank stays ns", 32'h0, l.secure);
    ovr = 4'hF;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("clamp high", 32'h8, ns_cnt);
    look(4'h7, 1'b0);
    chk("top bank ns", 32'h0, l.secure);
    give_verdict();
  end
endmodule
